//--- ptc_pin_model.sv
// Purpose: far-side pins of the timer: trigger source and external count clock
// Assumes: bench launches trigger requests just after a rising edge
// Notes:   count clock runs free at clk/8; unused unless an external code is chosen

`timescale 1ns/1ps
`default_nettype none

module ptc_pin_model
(
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // bench request
  input  wire logic trig_req,
  // pins toward the timer
  output logic      trig_in,
  output logic      ext_clk_in
);
  logic [1:0] div_reg;  // half-period counter of the count clock

  // trigger level follows the request, no extra stage
  assign trig_in = trig_req;

  // free count clock, changes only after an edge of clk
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_reg    <= 2'h0;
      ext_clk_in <= 1'b0;
    end
    else
    begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3)
        ext_clk_in <= ~ext_clk_in;
    end
  end
endmodule : ptc_pin_model

`default_nettype wire

//--- ptc_pkg.sv
// Purpose: shared constants and carrier types for the pwm timer control block
// Assumes: 16-bit register port, one clock phi (clk), async active-low reset
// Notes:   register map offsets are word indices on the plain register port

package ptc_pkg;

  // ---------------------------------------------------------------
  // register map (word indices)
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL     = 3'h0; // timer_control
  localparam logic [2:0] ADDR_CTRL_EXT = 3'h1; // timer_control_ext
  localparam logic [2:0] ADDR_CYCLE    = 3'h2; // cycle_setting
  localparam logic [2:0] ADDR_DUTY     = 3'h3; // duty_setting
  localparam logic [2:0] ADDR_TIMER    = 3'h4; // counter readback
  localparam logic [2:0] ADDR_STATUS   = 3'h5; // running / output state

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int BIT_RSVD_HI  = 15;
  localparam int CKS_HI       = 14;
  localparam int CKS_LO       = 12;
  localparam int BIT_RESTART  = 11;
  localparam int BIT_MASK     = 10;
  localparam int EGS_HI       = 9;
  localparam int EGS_LO       = 8;
  localparam int BIT_RSVD_LO  = 7;
  localparam int FMD_HI       = 6;
  localparam int FMD_LO       = 4;
  localparam int BIT_POL      = 3;
  localparam int BIT_ONESHOT  = 2;
  localparam int BIT_COUNT_ENABLE     = 1;
  localparam int BIT_SOFTWARE_TRIGGER     = 0;
  localparam int BIT_CKS_MSB  = 8;   // in timer_control_ext

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h7F7E; // stored bits only

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] FMD_RESET = 3'h0;
  localparam logic [2:0] FMD_PWM   = 3'h1;

  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [3:0] CKS_DIV1    = 4'h0;
  localparam logic [3:0] CKS_DIV4    = 4'h1;
  localparam logic [3:0] CKS_DIV16   = 4'h2;
  localparam logic [3:0] CKS_DIV128  = 4'h3;
  localparam logic [3:0] CKS_DIV256  = 4'h4;
  localparam logic [3:0] CKS_EXTR    = 4'h5;
  localparam logic [3:0] CKS_EXTF    = 4'h6;
  localparam logic [3:0] CKS_EXTB    = 4'h7;
  localparam logic [3:0] CKS_DIV512  = 4'h8;
  localparam logic [3:0] CKS_DIV1024 = 4'h9;
  localparam logic [3:0] CKS_DIV2048 = 4'hA;

  // ---------------------------------------------------------------
  // timing: extra trigger delay stages (external path = 2 cycles)
  // ---------------------------------------------------------------
  localparam int SOFT_TRIG_DELAY = 1;
  localparam int EXT_TRIG_DELAY  = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ptc_bus_t;

  typedef struct packed {
    logic        cks_msb;
    logic [2:0]  cks;
    logic        restart;
    logic        mask;
    logic [1:0]  edge_sel;
    logic [2:0]  function_select;
    logic        pol;
    logic        oneshot;
    logic        count_enable;
  } ptc_ctrl_t;

endpackage : ptc_pkg

//--- ptc_prescaler.sv
// Purpose: count clock tick generator for the down counter
// Assumes: external count clock is synchronous to clk
// Notes:   prescale counter runs free; ratio change applies at once

`timescale 1ns/1ps
`default_nettype none

module ptc_prescaler
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // control
  input  wire logic       run,        // counter running
  input  wire logic [3:0] sel,        // count clock select code
  // external count clock
  input  wire logic       ext_clk_in,
  // tick out
  output logic            tick
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [10:0] div;       // free prescale count
    logic        ext_prev;  // last external clock level
  } ptc_pre_state_t;

  ptc_pre_state_t s_reg;
  ptc_pre_state_t s_next;

  // all-ones test on the low bits of the prescaler
  function automatic logic low_ones(input logic [10:0] v, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      if (i < n)
        r = r & v[i];
    end
    return r;
  endfunction : low_ones

  // ---------------------------------------------------------------
  // next state and tick decode
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next          = s_reg;
    s_next.div      = s_reg.div + 11'h001;
    s_next.ext_prev = ext_clk_in;
    case (sel)
      ptc_pkg::CKS_DIV1:    tick = run;
      ptc_pkg::CKS_DIV4:    tick = run & low_ones(s_reg.div, 2);
      ptc_pkg::CKS_DIV16:   tick = run & low_ones(s_reg.div, 4);
      ptc_pkg::CKS_DIV128:  tick = run & low_ones(s_reg.div, 7);
      ptc_pkg::CKS_DIV256:  tick = run & low_ones(s_reg.div, 8);
      ptc_pkg::CKS_DIV512:  tick = run & low_ones(s_reg.div, 9);
      ptc_pkg::CKS_DIV1024: tick = run & low_ones(s_reg.div, 10);
      ptc_pkg::CKS_DIV2048: tick = run & low_ones(s_reg.div, 11);
      ptc_pkg::CKS_EXTR:    tick = run & ext_clk_in & ~s_reg.ext_prev;
      ptc_pkg::CKS_EXTF:    tick = run & ~ext_clk_in & s_reg.ext_prev;
      ptc_pkg::CKS_EXTB:    tick = run & (ext_clk_in ^ s_reg.ext_prev);
      default:              tick = 1'b0; // prohibited codes never count
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_reg <= '0;
    else if (ce)
      s_reg <= s_next;
  end

endmodule : ptc_prescaler

`default_nettype wire

//--- ptc_timer.sv
// Purpose: pwm timer channel control: register file, triggers, down counter, output
// Assumes: trigger and count clock pins synchronous to clk; port reads one cycle late
// Notes:   only the pwm function generates a waveform; other functions hold the counter, the reset function clears it

`timescale 1ns/1ps
`default_nettype none

module ptc_timer
(
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // register port
  input  wire ptc_pkg::ptc_bus_t bus,
  output logic [15:0]            rdata,
  // pins
  input  wire logic              trig_in,     // external trigger
  input  wire logic              ext_clk_in,  // external count clock
  output logic                   pwm_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,  // stopped or waiting for trigger
    ST_RUN  = 2'b01   // counting
  } ptc_state_t;

  typedef struct packed {
    ptc_pkg::ptc_ctrl_t ctrl;       // stored control bits
    logic [15:0]        cycle_buf;  // cycle_setting
    logic [15:0]        duty_buf;   // duty_setting (software side)
    logic [15:0]        duty_act;   // duty in force
    logic [15:0]        count;      // down counter
    ptc_state_t         state;
    logic               wave;       // raw waveform, normal sense
    logic               soft_pend;  // software trigger delay stage
    logic [1:0]         ext_pipe;   // external trigger delay stages
    logic               trig_prev;  // last trigger pin level
    logic [15:0]        rdata;      // read data register
  } ptc_top_state_t;

  ptc_top_state_t s_reg;
  ptc_top_state_t s_next;

  logic tick;       // count clock tick
  logic ext_edge;   // valid external trigger edge
  logic load;       // counter load this cycle
  logic w_ctrl;     // control write
  logic underflow;  // counter leaves zero

  // full control word as software sees it
  function automatic logic [15:0] ctrl_word(input ptc_pkg::ptc_ctrl_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[ptc_pkg::CKS_HI:ptc_pkg::CKS_LO] = c.cks;
    w[ptc_pkg::BIT_RESTART]            = c.restart;
    w[ptc_pkg::BIT_MASK]               = c.mask;
    w[ptc_pkg::EGS_HI:ptc_pkg::EGS_LO] = c.edge_sel;
    w[ptc_pkg::FMD_HI:ptc_pkg::FMD_LO] = c.function_select;
    w[ptc_pkg::BIT_POL]                = c.pol;
    w[ptc_pkg::BIT_ONESHOT]            = c.oneshot;
    w[ptc_pkg::BIT_COUNT_ENABLE]               = c.count_enable;
    return w; // reserved 15, 7 and trigger bit 0 stay zero
  endfunction : ctrl_word

  // ---------------------------------------------------------------
  // count clock
  // ---------------------------------------------------------------
  ptc_prescaler u_pre
  (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .run        (s_reg.state == ST_RUN),
    .sel        ({s_reg.ctrl.cks_msb, s_reg.ctrl.cks}),
    .ext_clk_in (ext_clk_in),
    .tick       (tick)
  );

  // ---------------------------------------------------------------
  // trigger edge detect
  // ---------------------------------------------------------------
  always_comb
  begin
    case (s_reg.ctrl.edge_sel)
      ptc_pkg::EDGE_RISE: ext_edge = trig_in & ~s_reg.trig_prev;
      ptc_pkg::EDGE_FALL: ext_edge = ~trig_in & s_reg.trig_prev;
      ptc_pkg::EDGE_BOTH: ext_edge = trig_in ^ s_reg.trig_prev;
      default:            ext_edge = 1'b0;  // disabled: pin never starts
    endcase
  end

  assign w_ctrl    = bus.wr && (bus.addr == ptc_pkg::ADDR_CTRL);
  assign underflow = (s_reg.state == ST_RUN) && tick && (s_reg.count == 16'h0000);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic active;   // counter allowed to act
    logic fired;    // delayed trigger reaches the counter
    active = s_reg.ctrl.count_enable && (s_reg.ctrl.function_select == ptc_pkg::FMD_PWM);
    fired  = 1'b0;
    s_next = s_reg;

    // register writes; field-change timing is left to software
    if (bus.wr)
    begin
      case (bus.addr)
        ptc_pkg::ADDR_CTRL:
        begin
          s_next.ctrl.cks      = bus.wdata[ptc_pkg::CKS_HI:ptc_pkg::CKS_LO];
          s_next.ctrl.restart  = bus.wdata[ptc_pkg::BIT_RESTART];
          s_next.ctrl.mask     = bus.wdata[ptc_pkg::BIT_MASK];
          s_next.ctrl.edge_sel = bus.wdata[ptc_pkg::EGS_HI:ptc_pkg::EGS_LO];
          s_next.ctrl.function_select      = bus.wdata[ptc_pkg::FMD_HI:ptc_pkg::FMD_LO];
          s_next.ctrl.pol      = bus.wdata[ptc_pkg::BIT_POL];
          s_next.ctrl.oneshot  = bus.wdata[ptc_pkg::BIT_ONESHOT];
          s_next.ctrl.count_enable     = bus.wdata[ptc_pkg::BIT_COUNT_ENABLE];
        end
        ptc_pkg::ADDR_CTRL_EXT: s_next.ctrl.cks_msb = bus.wdata[ptc_pkg::BIT_CKS_MSB];
        ptc_pkg::ADDR_CYCLE:    s_next.cycle_buf    = bus.wdata;
        ptc_pkg::ADDR_DUTY:     s_next.duty_buf     = bus.wdata;
        default:                s_next.ctrl = s_reg.ctrl;  // read-only or unmapped
      endcase
    end

    // software trigger: uses the written enable so both act together
    s_next.soft_pend = w_ctrl && bus.wdata[ptc_pkg::BIT_SOFTWARE_TRIGGER] && bus.wdata[ptc_pkg::BIT_COUNT_ENABLE];

    // external trigger takes two stages before the load
    s_next.trig_prev = trig_in;
    s_next.ext_pipe  = {s_reg.ext_pipe[0], ext_edge && active};

    fired = active && (s_reg.soft_pend || s_reg.ext_pipe[1]);

    // start when idle, restart only if enabled
    load = fired && ((s_reg.state == ST_IDLE) || s_reg.ctrl.restart);

    // counter; load beats a coinciding count
    if (load)
    begin
      s_next.count    = s_reg.cycle_buf;
      s_next.duty_act = s_reg.duty_buf;
      s_next.state    = ST_RUN;
      s_next.wave     = (s_reg.cycle_buf == s_reg.duty_buf);  // equal: active at once
    end
    else if (underflow)
    begin
      s_next.duty_act = s_reg.duty_buf;
      if (s_reg.ctrl.oneshot)
      begin
        s_next.count = 16'hFFFF;
        s_next.state = ST_IDLE;
        s_next.wave  = 1'b0;
      end
      else
      begin
        s_next.count = s_reg.cycle_buf;
        s_next.wave  = (s_reg.cycle_buf == s_reg.duty_buf);
      end
    end
    else if ((s_reg.state == ST_RUN) && tick)
    begin
      s_next.count = s_reg.count - 16'h0001;
      if ((s_reg.count - 16'h0001) == s_reg.duty_act)
        s_next.wave = 1'b1;               // duty match
    end

    // stop or non-pwm function halts the channel
    if (!active && !load)
      s_next.state = ST_IDLE;

    // enable written from zero to one: waveform low
    if (w_ctrl && bus.wdata[ptc_pkg::BIT_COUNT_ENABLE] && !s_reg.ctrl.count_enable)
      s_next.wave = 1'b0;

    // reset mode clears all timer state but the trigger pin level; the prescaler keeps its count
    if (w_ctrl && (bus.wdata[ptc_pkg::FMD_HI:ptc_pkg::FMD_LO] == ptc_pkg::FMD_RESET))
    begin
      s_next           = '0;
      s_next.trig_prev = trig_in;
    end

    // read data, valid one cycle after the strobe
    s_next.rdata = 16'h0000;
    if (bus.rd)
    begin
      case (bus.addr)
        ptc_pkg::ADDR_CTRL:     s_next.rdata = ctrl_word(s_reg.ctrl);
        ptc_pkg::ADDR_CTRL_EXT: s_next.rdata = {7'h00, s_reg.ctrl.cks_msb, 8'h00};
        ptc_pkg::ADDR_CYCLE:    s_next.rdata = s_reg.cycle_buf;
        ptc_pkg::ADDR_DUTY:     s_next.rdata = s_reg.duty_buf;
        ptc_pkg::ADDR_TIMER:    s_next.rdata = s_reg.count;
        ptc_pkg::ADDR_STATUS:   s_next.rdata = {14'h0000, pwm_out, s_reg.state == ST_RUN};
        default:                s_next.rdata = 16'h0000;  // unmapped reads zero
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output shaping: mask then polarity, so mask gives low or high
  // ---------------------------------------------------------------
  always_comb
  begin
    pwm_out = (s_reg.wave & ~s_reg.ctrl.mask) ^ s_reg.ctrl.pol;
  end

  assign rdata = s_reg.rdata;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_reg <= '0;
    else if (ce)
      s_reg <= s_next;
  end

endmodule : ptc_timer

`default_nettype wire

//--- ptc_timer_assertions.sv
// Purpose: port-level checks for the pwm timer control block
// Assumes: one clock domain, ce held high by the bench
// Notes:   shadows the last written enable to know when a start is fresh

`timescale 1ns/1ps
`default_nettype none

module ptc_timer_assertions
(
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              ce,
  // register port
  input wire ptc_pkg::ptc_bus_t bus,
  input wire logic [15:0]       rdata,
  // pins
  input wire logic              trig_in,
  input wire logic              ext_clk_in,
  input wire logic              pwm_out
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic ctl_wr;     // control write taken at this edge
  logic ctl_rd;     // control read taken at this edge
  logic pwm_wr;     // control write selecting the pwm function
  logic en_reg;     // enable last written as one
  logic fresh_reg;  // no start since the last clear, wave still low
  assign ctl_wr = ce && bus.wr && bus.addr == ptc_pkg::ADDR_CTRL;
  assign ctl_rd = ce && bus.rd && bus.addr == ptc_pkg::ADDR_CTRL;
  assign pwm_wr = ctl_wr && bus.wdata[6:4] == ptc_pkg::FMD_PWM;
  // conservative shadow: a one-shot end may leave en_reg set, which only weakens a check
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en_reg    <= 1'b0;
      fresh_reg <= 1'b1;
    end
    else if (ctl_wr)
    begin
      en_reg    <= bus.wdata[1] && bus.wdata[6:4] != ptc_pkg::FMD_RESET;
      fresh_reg <= bus.wdata[6:4] == ptc_pkg::FMD_RESET || (fresh_reg && !bus.wdata[1]);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  rdata_idle_a: assert property (ce && !bus.rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (ce && bus.rd && bus.addr > 3'h5 |=> rdata == 16'h0000)
    else $error("unmapped read returned nonzero data");
  ctrl_reserved_a: assert property (ctl_rd |=> rdata[15] == 1'b0 && rdata[7] == 1'b0 && rdata[0] == 1'b0)
    else $error("reserved or trigger bit read back as one");
  ctrl_readback_a: assert property (pwm_wr ##1 ctl_rd |=> rdata == ($past(bus.wdata, 2) & ptc_pkg::CTRL_WMASK))
    else $error("control read back differs from written value");
  soft_reset_a: assert property (ctl_wr && bus.wdata[6:4] == ptc_pkg::FMD_RESET ##1 ctl_rd |=> rdata == 16'h0000)
    else $error("reset mode did not clear control");
  mask_low_a: assert property (ctl_wr && bus.wdata[10] && !bus.wdata[3] |=> !pwm_out)
    else $error("mask did not force output low");
  mask_high_a: assert property (pwm_wr && bus.wdata[10] && bus.wdata[3] |=> pwm_out)
    else $error("inverted mask did not force output high");
  start_low_a: assert property (ctl_wr && bus.wdata[1] && !en_reg && !bus.wdata[3] |=> !pwm_out)
    else $error("enable write did not drive output low");
  idle_inverted_a: assert property (pwm_wr && fresh_reg && bus.wdata[3] && !bus.wdata[10] && !bus.wdata[1]
    |=> pwm_out)
    else $error("inverted idle output not high");

  // main scenarios seen
  start_c: cover property (pwm_wr && bus.wdata[1] && bus.wdata[0]);
  mask_c: cover property (pwm_wr && bus.wdata[10] && bus.wdata[3]);
  trig_c: cover property (ce && $rose(trig_in));
endmodule : ptc_timer_assertions

`default_nettype wire

//--- ptc_timer_tb_top.sv
// Purpose: self-checking bench for the pwm timer control block
// Assumes: register reads answer in the cycle after the strobe
// Notes:   each step call is one bus cycle; rdata seen after a step answers the prior step

`timescale 1ns/1ps
`default_nettype none

module ptc_timer_tb_top;
  logic              clk = 1'b0;      // 125 MHz
  logic              nrst = 1'b0;     // held low at start
  logic              ce = 1'b1;       // clock enable, always run
  logic              trig_req = 1'b0; // trigger pin request
  logic              trig_want = 1'b0;
  logic [15:0]       ctrl_last = 16'h0000; // last control word written
  ptc_pkg::ptc_bus_t bus = '0;
  logic [15:0]       rdata;
  logic              trig_in;
  logic              ext_clk_in;
  logic              pwm_out;
  int                num_errors = 0;
  int                comparisons = 0;
  logic [15:0] cnt_exp [0:8] = '{16'h0, 16'h3, 16'h2, 16'h1, 16'h0, 16'h3, 16'h2, 16'h1, 16'h0};
  logic        pwm_exp [0:8] = '{0, 0, 0, 1, 1, 0, 0, 1, 1};
  logic [1:0]  edge_tab [0:4] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic        rst_tab [0:4] = '{0, 0, 0, 0, 1};
  logic [15:0] exp1 [0:4] = '{16'h0, 16'h40, 16'h0, 16'h40, 16'h40};
  logic [15:0] exp2 [0:4] = '{16'h0, 16'h3B, 16'h40, 16'h3B, 16'h40};

  always #4 clk = ~clk;

  ptc_timer ptc_timer_i (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus), .rdata(rdata),
    .trig_in(trig_in), .ext_clk_in(ext_clk_in), .pwm_out(pwm_out));
  ptc_pin_model ptc_pin_model_i (.clk(clk), .nrst(nrst), .trig_req(trig_req),
    .trig_in(trig_in), .ext_clk_in(ext_clk_in));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // one bus cycle, launched just after an edge
  task automatic step(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    trig_req <= trig_want;
    #1;
  endtask : step
  task automatic idle();
    step(1'b0, 1'b0, 3'h0, 16'h0000);
  endtask : idle
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    if (a == ptc_pkg::ADDR_CTRL)
      ctrl_last = d;
    step(1'b1, 1'b0, a, d);
  endtask : wr
  // stop with every other field kept, so restricted fields change only while stopped
  task automatic stop();
    wr(ptc_pkg::ADDR_CTRL, ctrl_last & 16'h7F7C);
  endtask : stop
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    step(1'b0, 1'b1, a, 16'h0000);
    idle();
    check(rdata & m, e);
  endtask : rd_chk
  task automatic pchk(input logic e);
    check({15'h0000, pwm_out}, {15'h0000, e});
  endtask : pchk
  // clear through reset mode, then load cycle and duty while stopped
  task automatic prep(input logic [15:0] cyc, input logic [15:0] dut);
    stop();
    wr(ptc_pkg::ADDR_CTRL, 16'h0000);
    wr(ptc_pkg::ADDR_CYCLE, cyc);
    wr(ptc_pkg::ADDR_DUTY, dut);
  endtask : prep

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(ptc_pkg::ADDR_CTRL, 16'hFFFF, 16'h0000);
    pchk(1'b0);
    rd_chk(3'h6, 16'hFFFF, 16'h0000);
    wr(ptc_pkg::ADDR_CTRL, 16'h0018);
    idle();
    pchk(1'b1);
    wr(ptc_pkg::ADDR_CTRL, 16'h7F1D);
    rd_chk(ptc_pkg::ADDR_CTRL, 16'hFFFF, 16'h7F1C);
    pchk(1'b1);
    stop();
    wr(ptc_pkg::ADDR_CTRL, 16'h0410);
    idle();
    pchk(1'b0);
    wr(ptc_pkg::ADDR_CTRL, 16'h0000);
    rd_chk(ptc_pkg::ADDR_CTRL, 16'hFFFF, 16'h0000);
    wr(ptc_pkg::ADDR_CTRL_EXT, 16'h0100);
    rd_chk(ptc_pkg::ADDR_CTRL_EXT, 16'hFFFF, 16'h0100);
    // soft start, edges disabled, enable and trigger in one write
    prep(16'h0003, 16'h0001);
    wr(ptc_pkg::ADDR_CTRL, 16'h0013);
    for (int i = 0; i < 9; i++)
    begin
      step(1'b0, 1'b1, ptc_pkg::ADDR_TIMER, 16'h0000);
      pchk(pwm_exp[i]);
      if (i > 0)
        check(rdata, cnt_exp[i - 1]);
    end
    idle();
    check(rdata, cnt_exp[8]);
    wr(ptc_pkg::ADDR_CTRL, 16'h0011);
    idle();
    rd_chk(ptc_pkg::ADDR_STATUS, 16'h0001, 16'h0000);
    // cycle equal to duty, both polarities
    for (int p = 0; p < 2; p++)
    begin
      prep(16'h0002, 16'h0002);
      wr(ptc_pkg::ADDR_CTRL, 16'h0013 | (p[0] ? 16'h0008 : 16'h0000));
      idle();
      repeat (8)
      begin
        idle();
        pchk(~p[0]);
      end
    end
    // one-shot ends with counter wrapped and output low
    prep(16'h0002, 16'h0001);
    wr(ptc_pkg::ADDR_CTRL, 16'h0017);
    repeat (10) idle();
    rd_chk(ptc_pkg::ADDR_TIMER, 16'hFFFF, 16'hFFFF);
    rd_chk(ptc_pkg::ADDR_STATUS, 16'h0003, 16'h0000);
    // divide by four, then external rising edges: eight edges give two or one ticks
    for (int k = 0; k < 2; k++)
    begin
      prep(16'h0040, 16'h0010);
      wr(ptc_pkg::ADDR_CTRL, k ? 16'h5013 : 16'h1013);
      repeat (9) idle();
      rd_chk(ptc_pkg::ADDR_TIMER, 16'hFFFF, k ? 16'h003F : 16'h003E);
    end
    // external trigger edges, with and without restart
    for (int i = 0; i < 5; i++)
    begin
      prep(16'h0040, 16'h0010);
      wr(ptc_pkg::ADDR_CTRL, {4'h0, rst_tab[i], 1'b0, edge_tab[i], 8'h12});
      idle();
      trig_want = 1'b1;
      repeat (3) idle();
      rd_chk(ptc_pkg::ADDR_TIMER, 16'hFFFF, exp1[i]);
      trig_want = 1'b0;
      repeat (3) idle();
      rd_chk(ptc_pkg::ADDR_TIMER, 16'hFFFF, exp2[i]);
    end
    end_of_test();
  end

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule : ptc_timer_tb_top

bind ptc_timer ptc_timer_assertions ptc_timer_assertions_i (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus),
  .rdata(rdata), .trig_in(trig_in), .ext_clk_in(ext_clk_in), .pwm_out(pwm_out));

`default_nettype wire
